// >>> rtl/flsm_pkg.sv
/*
 * package for the fiber link status monitor: register offsets, field positions, reset values, carrier types.
 * assumes a 32-bit word register port with byte addresses on the board register path.
 */
package flsm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PORT_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LANE_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CRATE_ID = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MON_CTRL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_MON_STAT = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_MON_MASK = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_MON_VAL = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_MON_THR = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_MON_DATA = 8'h90;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] PORT_CTRL_MASK = 32'h07FF_FFFF;
  localparam int unsigned LANES = 4;
  localparam int unsigned POS_HARD_ERR = 0;
  localparam int unsigned POS_LANE_UP = 4;
  localparam int unsigned POS_RX_POL = 8;
  localparam int unsigned POS_CHAN_UP = 12;
  localparam int unsigned POS_TX_LOCK = 13;
  localparam int unsigned POS_RX_IDLE_N = 14;
  localparam int unsigned POS_ID_CLEAR = 0;
  localparam int unsigned POS_MON_RDY = 0;
  localparam int unsigned POS_CHECK_OK = 8;
  localparam int unsigned POS_LATENCY = 16;
  localparam int unsigned TICK_NS = 4;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned LAT_W = 16;
  localparam logic [LAT_W-1:0] LAT_MAX = 16'hFFFF;

  typedef struct packed {
    logic [LANES-1:0] lane_fatal_error;
    logic [LANES-1:0] lane_operational;
    logic [LANES-1:0] receive_polarity_inverted;
    logic [LANES-1:0] lane_check_passed;
    logic channel_operational;
    logic transmit_pll_locked;
  } flsm_link_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } flsm_req_t;
endpackage : flsm_pkg

// >>> rtl/flsm_sync.sv
/*
 * two-flop synchroniser for a vector of levels.
 * assumes inputs come from another clock domain or pins.
 */
`timescale 1ns/1ps
module flsm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule : flsm_sync

// >>> rtl/flsm_top.sv
/*
 * fiber link status monitor: control and status registers for one four-lane receive port.
 * assumes link status levels arrive from the transceiver domain and are synchronised here;
 * link words and SYNC are on clk_sys_i; register port is a single-cycle read/write strobe.
 */
// What this block does
// - port control register: two tile enables, write enable, address, 16-bit write data.
// - per-lane hard-error flag, sticky until reset.
// - per-lane flag reads one when receive polarity is inverted.
// - transmit PLL lock flag reads zero while unlocked.
// - receive-idle flag: reads one while the link is idle, zero while data arrives.
// - capture first low 16-bit word after each idle-to-data transition; an identifier clear in the same cycle wins and nothing is captured.
// - writing one to identifier clear zeroes the identifier; bit self-clears.
// - monitor-ready flag reads one once monitor triggered and data captured.
// - per-lane flag shows lane passed check in last sync frame.
// - latency from SYNC to first valid link word (any word, not only a trigger match), in ticks, upper 16 bits.
`timescale 1ns/1ps
module flsm_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register port
  input wire flsm_pkg::flsm_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // link status levels from transceiver
  input wire flsm_pkg::flsm_link_t link_i,
  input wire logic [flsm_pkg::LANES-1:0] lane_hard_error_i,
  // receive data path, system clock domain
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_data_i,
  input wire logic sync_i,
  // transceiver configuration port controls
  output logic [31:0] port_ctrl_o
);
  localparam int unsigned L = flsm_pkg::LANES;
  // ticks added per system clock
  localparam logic [flsm_pkg::LAT_W-1:0] LAT_STEP = 16'(flsm_pkg::CLK_NS / flsm_pkg::TICK_NS);

  flsm_pkg::flsm_link_t lnk;
  logic [L-1:0] herr_s;

  flsm_sync #(.W($bits(flsm_pkg::flsm_link_t) + L)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i({link_i, lane_hard_error_i}),
    .q_o({lnk, herr_s})
  );

  logic [31:0] port_ctrl_q, port_ctrl_d;
  logic [31:0] mask_q, mask_d, val_q, val_d, thr_q, thr_d, mdata_q, mdata_d;
  logic [L-1:0] herr_q, herr_d;
  logic [15:0] crate_q, crate_d;
  logic rx_prev_q, rx_prev_d;
  logic rdy_q, rdy_d;
  logic sync_prev_q, sync_prev_d;
  logic lat_run_q, lat_run_d;
  logic [flsm_pkg::LAT_W-1:0] lat_cnt_q, lat_cnt_d, lat_q, lat_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic wr_ctrl, wr_mon, id_clear, start_word, sync_fall;

  function automatic logic hit(input flsm_pkg::flsm_req_t r, input logic [flsm_pkg::ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  always_comb begin
    wr_ctrl = hit(req_i, flsm_pkg::OFS_PORT_CTRL);
    wr_mon = hit(req_i, flsm_pkg::OFS_MON_CTRL);
    id_clear = wr_mon && req_i.wdata[flsm_pkg::POS_ID_CLEAR];
    start_word = rx_valid_i && !rx_prev_q;
    sync_fall = sync_prev_q && !sync_i;

    port_ctrl_d = wr_ctrl ? (req_i.wdata & flsm_pkg::PORT_CTRL_MASK) : port_ctrl_q;
    mask_d = hit(req_i, flsm_pkg::OFS_MON_MASK) ? req_i.wdata : mask_q;
    val_d = hit(req_i, flsm_pkg::OFS_MON_VAL) ? req_i.wdata : val_q;
    thr_d = hit(req_i, flsm_pkg::OFS_MON_THR) ? req_i.wdata : thr_q;

    herr_d = herr_q | herr_s | lnk.lane_fatal_error;

    crate_d = crate_q;
    if (id_clear) begin
      crate_d = '0;
    end else if (start_word) begin
      crate_d = rx_data_i[15:0];
    end
    rx_prev_d = rx_valid_i;

    mdata_d = mdata_q;
    rdy_d = rdy_q;
    if (rx_valid_i && !rdy_q && ((rx_data_i & mask_q) == (val_q & mask_q))) begin
      rdy_d = 1'b1;
      mdata_d = rx_data_i;
    end

    sync_prev_d = sync_i;
    lat_run_d = lat_run_q;
    lat_cnt_d = lat_cnt_q;
    lat_d = lat_q;
    if (sync_fall) begin
      lat_run_d = 1'b1;
      lat_cnt_d = '0;
    end else if (lat_run_q) begin
      if (rx_valid_i) begin
        lat_run_d = 1'b0;
        lat_d = lat_cnt_q;
      end else if (lat_cnt_q > (flsm_pkg::LAT_MAX - LAT_STEP)) begin
        // saturate instead of wrapping past the top
        lat_cnt_d = flsm_pkg::LAT_MAX;
      end else begin
        lat_cnt_d = lat_cnt_q + LAT_STEP;
      end
    end

    rdata_d = flsm_pkg::RST_WORD;
    rvalid_d = req_i.rd;
    unique case (req_i.addr)
      flsm_pkg::OFS_PORT_CTRL: rdata_d = port_ctrl_q;
      flsm_pkg::OFS_LANE_STAT: begin
        rdata_d[flsm_pkg::POS_HARD_ERR +: L] = herr_q;
        rdata_d[flsm_pkg::POS_LANE_UP +: L] = lnk.lane_operational;
        rdata_d[flsm_pkg::POS_RX_POL +: L] = lnk.receive_polarity_inverted;
        rdata_d[flsm_pkg::POS_CHAN_UP] = lnk.channel_operational;
        rdata_d[flsm_pkg::POS_TX_LOCK] = lnk.transmit_pll_locked;
        rdata_d[flsm_pkg::POS_RX_IDLE_N] = !rx_valid_i;
      end
      flsm_pkg::OFS_CRATE_ID: rdata_d[15:0] = crate_q;
      flsm_pkg::OFS_MON_CTRL: rdata_d = flsm_pkg::RST_WORD;
      flsm_pkg::OFS_MON_STAT: begin
        rdata_d[flsm_pkg::POS_MON_RDY] = rdy_q;
        rdata_d[flsm_pkg::POS_CHECK_OK +: L] = lnk.lane_check_passed;
        rdata_d[flsm_pkg::POS_LATENCY +: flsm_pkg::LAT_W] = lat_q;
      end
      flsm_pkg::OFS_MON_MASK: rdata_d = mask_q;
      flsm_pkg::OFS_MON_VAL: rdata_d = val_q;
      flsm_pkg::OFS_MON_THR: rdata_d = thr_q;
      flsm_pkg::OFS_MON_DATA: rdata_d = mdata_q;
      default: rdata_d = flsm_pkg::RST_WORD;
    endcase
    if (!req_i.rd) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_ctrl_q <= flsm_pkg::RST_WORD;
      mask_q <= flsm_pkg::RST_WORD;
      val_q <= flsm_pkg::RST_WORD;
      thr_q <= flsm_pkg::RST_WORD;
      mdata_q <= flsm_pkg::RST_WORD;
      herr_q <= '0;
      crate_q <= '0;
      rx_prev_q <= 1'b0;
      rdy_q <= 1'b0;
      sync_prev_q <= 1'b0;
      lat_run_q <= 1'b0;
      lat_cnt_q <= '0;
      lat_q <= '0;
      rdata_q <= flsm_pkg::RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      port_ctrl_q <= port_ctrl_d;
      mask_q <= mask_d;
      val_q <= val_d;
      thr_q <= thr_d;
      mdata_q <= mdata_d;
      herr_q <= herr_d;
      crate_q <= crate_d;
      rx_prev_q <= rx_prev_d;
      rdy_q <= rdy_d;
      sync_prev_q <= sync_prev_d;
      lat_run_q <= lat_run_d;
      lat_cnt_q <= lat_cnt_d;
      lat_q <= lat_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign port_ctrl_o = port_ctrl_q;

  property p_herr_sticky;
    @(posedge clk_sys_i) disable iff (sys_rst_i) herr_q[0] |=> herr_q[0];
  endproperty
  a_herr_sticky: assert property (p_herr_sticky) else $error("hard error flag dropped");

  property p_herr_set;
    @(posedge clk_sys_i) disable iff (sys_rst_i) herr_s[1] |=> herr_q[1];
  endproperty
  a_herr_set: assert property (p_herr_set) else $error("hard error not latched");

  property p_id_clear;
    @(posedge clk_sys_i) disable iff (sys_rst_i) id_clear |=> (crate_q == 16'h0000);
  endproperty
  a_id_clear: assert property (p_id_clear) else $error("identifier not cleared");

  property p_id_capture;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (start_word && !id_clear) |=> (crate_q == $past(rx_data_i[15:0]));
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identifier not captured");

  property p_id_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i) (!start_word && !id_clear) |=> $stable(crate_q);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("identifier changed without cause");

  property p_rdy_sticky;
    @(posedge clk_sys_i) disable iff (sys_rst_i) rdy_q |=> rdy_q;
  endproperty
  a_rdy_sticky: assert property (p_rdy_sticky) else $error("ready flag dropped");

  property p_lat_store;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (lat_run_q && rx_valid_i && !sync_fall) |=> (lat_q == $past(lat_cnt_q)) && !lat_run_q;
  endproperty
  a_lat_store: assert property (p_lat_store) else $error("latency not stored");

  property p_lat_start;
    @(posedge clk_sys_i) disable iff (sys_rst_i) sync_fall |=> lat_run_q && (lat_cnt_q == 16'h0000);
  endproperty
  a_lat_start: assert property (p_lat_start) else $error("latency count not started");

  property p_idle_read;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (req_i.rd && req_i.addr == flsm_pkg::OFS_LANE_STAT) |=>
      (rdata_o[flsm_pkg::POS_RX_IDLE_N] == !$past(rx_valid_i));
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("idle flag wrong");

  property p_ctrl_wr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      wr_ctrl |=> (port_ctrl_o == ($past(req_i.wdata) & flsm_pkg::PORT_CTRL_MASK));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("port control write lost");
endmodule : flsm_top

// >>> verif/flsm_far_end.sv
/*
 * far-end sender model: streams link words while go_i is high.
 * assumes the bench raises go_i on a falling edge; words follow word_i upward.
 */
`timescale 1ns/1ps
module flsm_far_end (
  // clock
  input wire logic clk_sys_i,
  // command from bench
  input wire logic go_i,
  input wire logic [31:0] word_i,
  // link towards receiver
  output logic rx_valid_o,
  output logic [31:0] rx_data_o
);
  logic [31:0] cnt_q = 32'h0000_0000;
  initial rx_valid_o = 1'b0;
  initial rx_data_o = 32'h0000_0000;
  // changes just after the falling edge, never on the sampling edge
  always @(negedge clk_sys_i) begin
    #1;
    if (go_i) begin
      rx_valid_o = 1'b1;
      rx_data_o = word_i + cnt_q;
      cnt_q = cnt_q + 32'h0000_0001;
    end else begin
      // idle link inverts the held word each cycle, so the stale word shows every other cycle
      rx_valid_o = 1'b0;
      rx_data_o = ~rx_data_o;
      cnt_q = 32'h0000_0000;
    end
  end
endmodule : flsm_far_end

// >>> verif/fiber_link_status_monitor_test.sv
/*
 * register-level bench for the link status monitor.
 * assumes the strobe register port and the far-end model in flsm_far_end.
 */
`timescale 1ns/1ps
module fiber_link_status_monitor_test;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  flsm_pkg::flsm_req_t req = '0;
  flsm_pkg::flsm_link_t link = '0;
  logic [3:0] herr = 4'h0;
  logic sync = 1'b1;
  logic go = 1'b0;
  logic rx_valid;
  logic rvalid;
  logic [31:0] rx_data;
  logic [31:0] rdata;
  logic [31:0] port_ctrl;
  logic [31:0] word;
  logic [7:0] rst_ofs [9] = '{8'h0C, 8'h10, 8'h20, 8'h30, 8'h34, 8'h40, 8'h60, 8'h80, 8'h90};
  int error_cnt = 0;
  int n_compared = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  flsm_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .link_i(link), .lane_hard_error_i(herr), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .sync_i(sync),
    .port_ctrl_o(port_ctrl));
  flsm_far_end far (.clk_sys_i(clk_sys_i), .go_i(go), .word_i(32'hA5C3_1234), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data));

  task automatic finish_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_sys_i);
    req.wr = 1'b0;
  endtask : wr

  // answer pulse stands in the cycle after the strobe edge
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_sys_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_sys_i);
    req.rd = 1'b0;
    chk({31'h0, rvalid}, 32'h0000_0001);
    chk(rdata, exp);
  endtask : rchk

  initial begin
    cyc(20);
    sys_rst_i = 1'b0;
    foreach (rst_ofs[i]) rchk(rst_ofs[i], rst_ofs[i] == 8'h10 ? 32'h0000_4000 : 32'h0000_0000);
    rchk(8'h50, 32'h0000_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rchk(8'h0C, 32'h07FF_FFFF);
    chk(port_ctrl, 32'h07FF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0000_4000);
    link.lane_operational = 4'hA;
    link.receive_polarity_inverted = 4'h5;
    link.lane_check_passed = 4'h9;
    link.channel_operational = 1'b1;
    herr = 4'h6;
    cyc(2);
    herr = 4'h0;
    cyc(4);
    rchk(8'h10, 32'h0000_55A6);
    link.transmit_pll_locked = 1'b1;
    cyc(4);
    rchk(8'h10, 32'h0000_75A6);
    wr(8'h40, 32'hFFFF_FFFF);
    wr(8'h60, 32'hA5C3_1236);
    wr(8'h80, 32'h0000_0055);
    rchk(8'h80, 32'h0000_0055);
    // sync falls, first word seen five edges later
    sync = 1'b0;
    cyc(5);
    go = 1'b1;
    cyc(3);
    go = 1'b0;
    sync = 1'b1;
    cyc(3);
    rchk(8'h34, 32'h0028_0901);
    rchk(8'h90, 32'hA5C3_1236);
    rchk(8'h20, 32'h0000_1234);
    wr(8'h30, 32'h0000_0000);
    rchk(8'h20, 32'h0000_1234);
    wr(8'h30, 32'h0000_0001);
    rchk(8'h30, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    go = 1'b1;
    cyc(2);
    rchk(8'h10, 32'h0000_35A6);
    go = 1'b0;
    rchk(8'h20, 32'h0000_1234);
    link.lane_fatal_error = 4'h8;
    cyc(2);
    link.lane_fatal_error = 4'h0;
    cyc(4);
    rchk(8'h10, 32'h0000_75AE);
    // second reset clears the sticky flags
    sys_rst_i = 1'b1;
    cyc(2);
    sys_rst_i = 1'b0;
    cyc(4);
    rchk(8'h10, 32'h0000_75A0);
    rchk(8'h34, 32'h0000_0900);
    finish_test();
  end

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
endmodule : fiber_link_status_monitor_test
